/* File: src/dbg_pkg.sv */
/*
  shared constants and carrier types of the two-wire debug serial port.
  assumes nothing beyond a SystemVerilog compiler; every user writes dbg_pkg::name.
*/
package dbg_pkg;

  // ****************************************************************
  // widths and counts
  // ****************************************************************
  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam int BUF_DEPTH = 2;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  // ****************************************************************
  // debug register space limits
  // ****************************************************************
  localparam logic [ADDR_W-1:0] WR_LAST = 7'h30;
  localparam logic [ADDR_W-1:0] RD_LAST = 7'h20;
  localparam logic [ADDR_W-1:0] ADDR_STEP = 7'h01;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic PIN_IDLE = 1'b1;
  localparam logic DIR_WRITE = 1'b0;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SEP,
    ST_DATA
  } state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } wr_word_t;

endpackage

/* File: src/dbg_word_buffer.sv */
/*
  small first-in first-out buffer with valid and ready on both sides.
  assumes one clock and an already synchronised active-low reset.
*/
module dbg_word_buffer #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 2
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_o = (count_reg != CNT_FULL);
  assign out_valid_o = (count_reg != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_reg[rd_ptr_reg];

  // ****************************************************************
  // storage, one entry per loop pass
  // ****************************************************************
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mem_reg[i] <= '0;
      end else if (push && (wr_ptr_reg == PW'(i))) begin
        mem_reg[i] <= in_data_i;
      end
    end
  end

  // ****************************************************************
  // pointers and fill level
  // ****************************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + PW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + CW'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - CW'(1);
      end
    end
  end

endmodule

/* File: src/debug_serial_port.sv */
/*
  two-wire debug serial slave: start detection, address and direction byte,
  block reads and writes into a private debug register space.
  assumes the register space answers rd_data_i combinationally from rd_addr_o
  on clock_i, and that the pin clock runs at most at half of clock_i.
*/
// Functional notes
// (RULE1) data line changes only while clock is low, except at a start
// (RULE2) start is data falling while clock high; every command begins so
// (RULE3) watch lines for start always; ignore activity until one is seen
// (RULE4) data rising while clock high has no effect at all
// (RULE5) bytes travel most significant bit first
// (RULE6) a byte takes nine clocks: eight data, one separator
// (RULE7) incoming write bits sampled on rising clock edge
// (RULE8) outgoing read bits driven on falling clock edge
// (RULE9) master ends by stopping in ninth cycle with clock high
// (RULE10) master holds data high before separator rising edge
// (RULE11) address advances by one during each separator bit; code skips the separator after the address byte
// (RULE12) start in separator ends sequence and begins fresh address
// (RULE13) seven address bits, then direction bit, 0 write 1 read
// (RULE14) one address names separate read-only and write-only registers
// (RULE15) single write captures data on eight rising edges after separator
// (RULE16) block write address stops advancing at last write address
// (RULE17) read loads register at first cycle after separator, msb first
// (RULE18) block read address stops advancing at last read address
// (RULE19) master clock at most half the system clock
// (RULE20) debug accesses leave processor execution state undisturbed
// (RULE21) break halts only the processor; other logic keeps running
// (RULE22) debug accesses have the same side effects as processor accesses
// (RULE23) both lines synchronised to system clock and edges found there
// (RULE24) unspecified clock edges leave shifter, counter and address unchanged
module debug_serial_port #(
  parameter int FIFO_DEPTH = dbg_pkg::BUF_DEPTH
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic debug_clock_pin_i,
  input wire logic debug_data_pin_i,
  output logic debug_data_pin_o,
  output logic debug_data_pin_oe_n_o,
  output logic [dbg_pkg::ADDR_W-1:0] rd_addr_o,
  output logic rd_write_space_o,
  output logic rd_strobe_o,
  input wire logic [dbg_pkg::BYTE_W-1:0] rd_data_i,
  output dbg_pkg::wr_word_t wr_word_o,
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic overrun_o,
  output logic busy_o
);

  localparam int WW = $bits(dbg_pkg::wr_word_t);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_reg <= '0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
  logic scl_rise, scl_fall, start_det;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      scl_meta_reg <= dbg_pkg::PIN_IDLE;
      scl_sync_reg <= dbg_pkg::PIN_IDLE;
      scl_prev_reg <= dbg_pkg::PIN_IDLE;
      sda_meta_reg <= dbg_pkg::PIN_IDLE;
      sda_sync_reg <= dbg_pkg::PIN_IDLE;
      sda_prev_reg <= dbg_pkg::PIN_IDLE;
    end else begin
      scl_meta_reg <= debug_clock_pin_i; // RULE23
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= debug_data_pin_i;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  assign scl_rise = scl_sync_reg && !scl_prev_reg; // RULE23
  assign scl_fall = !scl_sync_reg && scl_prev_reg;
  // only a falling data line under a steady high clock counts; a rising one is dropped
  assign start_det = scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg; // RULE2 RULE4

  // ****************************************************************
  // byte sequencer
  // ****************************************************************
  dbg_pkg::state_t state_reg;
  logic [2:0] bit_cnt_reg;
  logic in_data_reg;
  logic rw_reg;
  logic byte_done;
  logic sep_done;

  assign byte_done = scl_rise && (bit_cnt_reg == dbg_pkg::BIT_LAST);
  assign sep_done = scl_rise && (state_reg == dbg_pkg::ST_SEP);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= dbg_pkg::ST_IDLE;
      bit_cnt_reg <= dbg_pkg::BIT_FIRST;
      in_data_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= dbg_pkg::ST_ADDR; // RULE3 RULE12
      bit_cnt_reg <= dbg_pkg::BIT_FIRST;
      in_data_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        dbg_pkg::ST_IDLE: state_reg <= dbg_pkg::ST_IDLE; // RULE3
        dbg_pkg::ST_ADDR, dbg_pkg::ST_DATA: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1; // RULE6
            if (byte_done) begin
              state_reg <= dbg_pkg::ST_SEP;
            end
          end
        end
        dbg_pkg::ST_SEP: begin
          // separator rise: the ninth clock, data line value is the master's business
          if (scl_rise) begin
            state_reg <= dbg_pkg::ST_DATA; // RULE6 RULE10
            bit_cnt_reg <= dbg_pkg::BIT_FIRST;
            in_data_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // receive shifter
  // ****************************************************************
  logic [dbg_pkg::BYTE_W-1:0] rx_reg;
  logic rx_shift;

  assign rx_shift = scl_rise && ((state_reg == dbg_pkg::ST_ADDR)
                    || ((state_reg == dbg_pkg::ST_DATA) && (rw_reg == dbg_pkg::DIR_WRITE)));

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_reg <= '0;
    end else if (rx_shift && !start_det) begin
      rx_reg <= {rx_reg[dbg_pkg::BYTE_W-2:0], sda_sync_reg}; // RULE5 RULE7 RULE24
    end
  end

  // ****************************************************************
  // register address and direction
  // ****************************************************************
  logic [dbg_pkg::ADDR_W-1:0] addr_reg;
  logic [dbg_pkg::ADDR_W-1:0] addr_limit;

  assign addr_limit = (rw_reg == dbg_pkg::DIR_WRITE) ? dbg_pkg::WR_LAST : dbg_pkg::RD_LAST;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= '0;
      rw_reg <= dbg_pkg::DIR_WRITE;
    end else if (!start_det) begin
      if ((state_reg == dbg_pkg::ST_ADDR) && byte_done) begin
        addr_reg <= rx_reg[dbg_pkg::ADDR_W-1:0]; // RULE13
        rw_reg <= sda_sync_reg; // RULE13
      end else if (sep_done && in_data_reg && (addr_reg < addr_limit)) begin
        addr_reg <= addr_reg + dbg_pkg::ADDR_STEP; // RULE11 RULE16 RULE18
      end
    end
  end

  // the direction picks which of the two registers at one address is reached
  assign rd_addr_o = addr_reg; // RULE14 RULE20
  assign rd_write_space_o = (rw_reg == dbg_pkg::DIR_WRITE); // RULE14
  assign busy_o = (state_reg != dbg_pkg::ST_IDLE); // RULE21

  // ****************************************************************
  // write path: holding word, then two-entry buffer
  // ****************************************************************
  dbg_pkg::wr_word_t wr_hold_reg;
  logic wr_pend_reg;
  logic wr_take, wr_set;
  logic buf_ready;
  logic overrun_reg;
  logic [WW-1:0] buf_out;

  assign wr_set = (state_reg == dbg_pkg::ST_DATA) && (rw_reg == dbg_pkg::DIR_WRITE)
                  && byte_done && !start_det;
  assign wr_take = wr_pend_reg && buf_ready;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_hold_reg <= '0;
      wr_pend_reg <= 1'b0;
    end else if (wr_set) begin
      // a new byte wins over the hand-off in the same cycle
      wr_hold_reg.addr <= addr_reg; // RULE15 RULE22
      wr_hold_reg.data <= {rx_reg[dbg_pkg::BYTE_W-2:0], sda_sync_reg}; // RULE15
      wr_pend_reg <= 1'b1;
    end else if (wr_take) begin
      wr_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      overrun_reg <= 1'b0;
    end else if (wr_set && wr_pend_reg && !buf_ready) begin
      overrun_reg <= 1'b1;
    end
  end
  assign overrun_o = overrun_reg;

  dbg_word_buffer #(
    .WIDTH(WW),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_buf (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .in_data_i(wr_hold_reg),
    .in_valid_i(wr_pend_reg),
    .in_ready_o(buf_ready),
    .out_data_o(buf_out),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i)
  );
  assign wr_word_o = dbg_pkg::wr_word_t'(buf_out);

  // ****************************************************************
  // transmit shifter and pin drive
  // ****************************************************************
  logic [dbg_pkg::BYTE_W-1:0] tx_reg;
  logic load_pend_reg;
  logic tx_load, tx_shift;
  logic sda_out_reg;
  logic oe_n_reg;
  logic rd_strobe_reg;

  assign tx_load = scl_fall && load_pend_reg && (state_reg == dbg_pkg::ST_DATA);
  assign tx_shift = scl_fall && !load_pend_reg && (state_reg == dbg_pkg::ST_DATA)
                    && (rw_reg != dbg_pkg::DIR_WRITE);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      load_pend_reg <= 1'b0;
    end else if (start_det) begin
      load_pend_reg <= 1'b0;
    end else if (sep_done && (rw_reg != dbg_pkg::DIR_WRITE)) begin
      load_pend_reg <= 1'b1; // RULE17
    end else if (tx_load) begin
      load_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg <= '0;
      sda_out_reg <= dbg_pkg::PIN_IDLE;
      oe_n_reg <= 1'b1;
    end else if (start_det) begin
      oe_n_reg <= 1'b1;
    end else if (tx_load) begin
      tx_reg <= {rd_data_i[dbg_pkg::BYTE_W-2:0], 1'b0}; // RULE17
      sda_out_reg <= rd_data_i[dbg_pkg::BYTE_W-1]; // RULE1 RULE5 RULE8 RULE17
      oe_n_reg <= 1'b0;
    end else if (tx_shift) begin
      tx_reg <= {tx_reg[dbg_pkg::BYTE_W-2:0], 1'b0}; // RULE8 RULE24
      sda_out_reg <= tx_reg[dbg_pkg::BYTE_W-1];
    end else if (scl_fall && (state_reg == dbg_pkg::ST_SEP)) begin
      oe_n_reg <= 1'b1; // RULE10
    end
  end

  // read strobe lets the register space apply the same side effects as the processor
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_strobe_reg <= 1'b0;
    end else begin
      rd_strobe_reg <= tx_load; // RULE22
    end
  end

  assign rd_strobe_o = rd_strobe_reg;
  assign debug_data_pin_o = sda_out_reg;
  assign debug_data_pin_oe_n_o = oe_n_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n);

  a_start_opens_addr: assert property (start_det |=> (state_reg == dbg_pkg::ST_ADDR)
      && (bit_cnt_reg == dbg_pkg::BIT_FIRST)) // RULE2
    else $error("start did not open an address byte");
  a_idle_stays_idle: assert property ((state_reg == dbg_pkg::ST_IDLE) && !start_det
      |=> (state_reg == dbg_pkg::ST_IDLE) && oe_n_reg) // RULE3
    else $error("slave left idle without a start");
  a_rising_data_ignored: assert property (scl_sync_reg && scl_prev_reg && sda_sync_reg
      && !sda_prev_reg |=> $stable(state_reg) && $stable(addr_reg)) // RULE4
    else $error("rising data under high clock changed state");
  a_write_byte_held: assert property (wr_set |=> wr_pend_reg
      && (wr_hold_reg.addr == $past(addr_reg))) // RULE15
    else $error("received write byte not held with its address");
  a_addr_steps_one: assert property (sep_done && in_data_reg && !start_det
      && (addr_reg < addr_limit) |=> addr_reg == $past(addr_reg) + dbg_pkg::ADDR_STEP) // RULE11
    else $error("address did not advance by one at separator");
  a_write_addr_stops: assert property (sep_done && in_data_reg && !start_det
      && (rw_reg == dbg_pkg::DIR_WRITE) && (addr_reg == dbg_pkg::WR_LAST)
      |=> addr_reg == dbg_pkg::WR_LAST) // RULE16
    else $error("write address moved past its last register");
  a_read_addr_stops: assert property (sep_done && in_data_reg && !start_det
      && (rw_reg != dbg_pkg::DIR_WRITE) && (addr_reg == dbg_pkg::RD_LAST)
      |=> addr_reg == dbg_pkg::RD_LAST) // RULE18
    else $error("read address moved past its last register");
  a_read_msb_first: assert property (tx_load && !start_det |=> !oe_n_reg && rd_strobe_o
      && (sda_out_reg == $past(rd_data_i[dbg_pkg::BYTE_W-1])) ##1 !rd_strobe_o) // RULE17
    else $error("read byte not loaded msb first");
  a_write_never_drives: assert property ((rw_reg == dbg_pkg::DIR_WRITE)
      && (state_reg == dbg_pkg::ST_DATA) && oe_n_reg |=> oe_n_reg) // RULE8
    else $error("pin driven during a write");
  a_fall_keeps_rx: assert property (scl_fall && !scl_rise
      |=> $stable(rx_reg) && $stable(bit_cnt_reg)) // RULE24
    else $error("falling clock disturbed receive shifter or counter");
  a_drive_clock_low: assert property ($changed(sda_out_reg) |-> !scl_sync_reg) // RULE1
    else $error("slave changed data while clock high");

endmodule

/* File: test/dbg_master_model.sv */
/*
  behavioural serial master for the debug serial port: start, bytes, separators.
  assumes the bench resolves the data line (pull-up when nobody drives) and feeds it back
  on line_i; all changes are made at falling edges of clock_i.
*/
module dbg_master_model (
  input wire logic clock_i,
  input wire logic line_i,
  output logic link_clk_o,
  output logic data_o,
  output logic data_en_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // idle: clock high, data released
  // ****************************************************************
  initial begin
    link_clk_o = 1'b1;
    data_o = 1'b1;
    data_en_o = 1'b0;
  end

  // a half period of four system clocks gives the 160 ns link period
  task automatic w(input int n);
    repeat (n) @(negedge clock_i);
  endtask

  // data raised while the clock is low, then pulled low under a high clock
  task automatic start;
    data_en_o = 1'b1;
    data_o = 1'b1;
    w(4);
    link_clk_o = 1'b1;
    w(4);
    data_o = 1'b0;
    w(4);
    link_clk_o = 1'b0;
  endtask

  // g raises the data line in mid high phase, a change that must do nothing
  task automatic bit_out(input logic b, input bit g);
    data_en_o = 1'b1;
    data_o = b;
    w(4);
    link_clk_o = 1'b1;
    w(2);
    if (g) begin
      data_o = 1'b1;
    end
    w(2);
    link_clk_o = 1'b0;
  endtask

  task automatic bit_in(output logic b);
    data_en_o = 1'b0;
    w(4);
    link_clk_o = 1'b1;
    w(3);
    b = line_i;
    w(1);
    link_clk_o = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] b, input bit g);
    for (int i = 7; i >= 0; i--) begin
      bit_out(b[i], g && (i == 0));
    end
  endtask

  task automatic recv_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      bit_in(b[i]);
    end
  endtask

  // ninth bit: line released high; the last one leaves the clock high
  task automatic sep(input bit last);
    data_en_o = 1'b0;
    w(4);
    link_clk_o = 1'b1;
    w(4);
    if (!last) begin
      link_clk_o = 1'b0;
    end
  endtask
endmodule

/* File: test/tb_top.sv */
/*
  self-checking bench for debug_serial_port with a serial master model, a register
  space model and a stalling consumer of write words.
  assumes dbg_pkg and the design files are compiled first.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // clock, reset and wiring
  // ****************************************************************
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  always #10 clock_i = ~clock_i;

  logic lclk, mdat, men, line, pin_o, oe_n, rd_ws, rd_stb, wr_valid, overrun, busy;
  logic wr_ready = 1'b0;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  dbg_pkg::wr_word_t wr_word;
  int failures = 0;
  int compares = 0;
  int seed = 80;
  int strobes = 0;
  logic mid_bit;
  bit stall = 1'b0;
  logic [14:0] got[$];
  logic [14:0] exp[$];

  function automatic logic [7:0] regval(input logic [6:0] a);
    return ({1'b0, a} * 8'h13) + 8'h07;
  endfunction

  // pull-up on the data line when neither side drives it
  assign line = !oe_n ? pin_o : (men ? mdat : 1'b1);
  assign rd_data = rd_ws ? 8'h00 : regval(rd_addr);

  debug_serial_port i_debug_serial_port (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .debug_clock_pin_i(lclk),
    .debug_data_pin_i(line),
    .debug_data_pin_o(pin_o),
    .debug_data_pin_oe_n_o(oe_n),
    .rd_addr_o(rd_addr),
    .rd_write_space_o(rd_ws),
    .rd_strobe_o(rd_stb),
    .rd_data_i(rd_data),
    .wr_word_o(wr_word),
    .wr_valid_o(wr_valid),
    .wr_ready_i(wr_ready),
    .overrun_o(overrun),
    .busy_o(busy)
  );

  dbg_master_model i_dbg_master_model (
    .clock_i(clock_i),
    .line_i(line),
    .link_clk_o(lclk),
    .data_o(mdat),
    .data_en_o(men)
  );

  // consumer: random stalls, or a full stall while stall is set
  always @(negedge clock_i) begin
    wr_ready <= !stall && (($random(seed) & 3) != 0);
  end

  always @(posedge clock_i) begin
    if (wr_valid && wr_ready) begin
      got.push_back(wr_word);
    end
    if (rd_stb) begin
      strobes++;
    end
  end

  // ****************************************************************
  // checking and closing
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    compares++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t %s: got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic end_of_test;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #300us;
    failures++;
    end_of_test;
  end

  // ****************************************************************
  // commands with the behavioural model
  // ****************************************************************
  task automatic write_block(input logic [6:0] a, input int n, input bit g, input int skip);
    logic [7:0] d;
    int x;
    x = a;
    i_dbg_master_model.start();
    i_dbg_master_model.send_byte({a, 1'b0}, g);
    i_dbg_master_model.sep(1'b0);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      i_dbg_master_model.send_byte(d, 1'b0);
      i_dbg_master_model.sep(i == n - 1);
      if (i != skip) begin
        exp.push_back({7'(x), d});
      end
      if (x < 'h30) begin
        x++;
      end
    end
    i_dbg_master_model.w(4);
    chk(rd_addr, x, "write end address");
    chk(rd_ws, 1'b1, "write space");
  endtask

  task automatic cmp_words;
    for (int k = 0; k < 400 && got.size() < exp.size(); k++) begin
      @(posedge clock_i);
    end
    chk(got.size(), exp.size(), "word count");
    foreach (exp[i]) begin
      if (i < got.size()) begin
        chk(got[i], exp[i], "write word");
      end
    end
    got.delete();
    exp.delete();
  endtask

  task automatic read_block(input logic [6:0] a, input int n);
    logic [7:0] d;
    int x;
    x = a;
    i_dbg_master_model.start();
    i_dbg_master_model.send_byte({a, 1'b1}, 1'b0);
    i_dbg_master_model.sep(1'b0);
    strobes = 0;
    for (int i = 0; i < n; i++) begin
      i_dbg_master_model.recv_byte(d);
      i_dbg_master_model.sep(i == n - 1);
      chk(d, regval(7'(x)), "read byte");
      if (x < 'h20) begin
        x++;
      end
    end
    i_dbg_master_model.w(4);
    chk(strobes, n, "read loads");
    chk(oe_n, 1'b1, "line released");
    chk(rd_ws, 1'b0, "read space");
    chk(rd_addr, x, "read end address");
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (20) @(negedge clock_i);
    nrst_i = 1'b1;
    @(negedge clock_i);
    chk({oe_n, busy, wr_valid, overrun, rd_ws}, 5'b1_0001, "reset outputs");
    chk(rd_addr, 7'h00, "reset address");
    i_dbg_master_model.w(6);
    // first bit keeps the line high, so lowering the idle-high clock is not a start
    for (int i = 1; i < 6; i++) begin
      i_dbg_master_model.bit_out(i[0], 1'b0);
    end
    i_dbg_master_model.w(4);
    chk(busy, 1'b0, "no command before start");
    chk(got.size(), 0, "no word before start");
    i_dbg_master_model.start();
    i_dbg_master_model.w(4);
    chk(busy, 1'b1, "start seen");
    for (int i = 0; i < 3; i++) begin
      i_dbg_master_model.bit_out(1'b1, 1'b0);
    end
    write_block(7'h2E, 4, 1'b1, -1);
    cmp_words;
    write_block(7'h00, 1, 1'b0, -1);
    cmp_words;
    read_block(7'h00, 1);
    read_block(7'h1E, 4);
    for (int k = 0; k < 3; k++) begin
      read_block(7'($random(seed)), 1 + (($random(seed) & 32'h7fff_ffff) % 3));
      write_block(7'($random(seed)), 1 + (($random(seed) & 32'h7fff_ffff) % 3), 1'b0, -1);
      cmp_words;
    end
    // reset in the middle of a read byte while the slave drives the line
    i_dbg_master_model.start();
    i_dbg_master_model.send_byte({7'h11, 1'b1}, 1'b0);
    i_dbg_master_model.sep(1'b0);
    i_dbg_master_model.bit_in(mid_bit);
    chk(mid_bit, regval(7'h11) >> 7, "first read bit");
    chk(oe_n, 1'b0, "read drives line");
    nrst_i = 1'b0;
    @(negedge clock_i);
    chk({oe_n, busy, wr_valid, overrun, rd_ws}, 5'b1_0001, "mid reset outputs");
    chk(rd_addr, 7'h00, "mid reset address");
    repeat (3) @(negedge clock_i);
    nrst_i = 1'b1;
    i_dbg_master_model.w(6);
    read_block(7'h1F, 2);
    chk(overrun, 1'b0, "no overrun yet");
    stall = 1'b1;
    write_block(7'h05, 4, 1'b0, 2);
    chk(overrun, 1'b1, "overrun flagged");
    chk(wr_valid, 1'b1, "buffer holds words");
    stall = 1'b0;
    cmp_words;
    end_of_test;
  end
endmodule
